// ===== hw/acms_pkg.sv
// Operation
// - Off state shuts everything, ignores bus
// - Standby keeps digital only, bus alive
// - Active bit enables all blocks
// - Active to standby keeps all registers (code clears data_valid_o and the start-up counters)
// - Standby to active resets designated registers
// - Sleep and wake exist only in active
// - Scale 1024, 512, 256 counts per g
// - Two's-complement axis data from address 0x00
// - Self-test adds stimulus before range scaling
// - Suppress bus glitches up to 50 ns
// - Valid data after two samples plus 1 ms
package acms_pkg;

  // ==========================================================================
  // Operating modes and ranges
  typedef enum logic [1:0] {
    ACMS_OFF   = 2'b00,
    ACMS_STBY  = 2'b01,
    ACMS_WAKE  = 2'b10,
    ACMS_SLEEP = 2'b11
  } acms_mode_t;

  typedef enum logic [1:0] {
    ACMS_FS_2G = 2'b00,
    ACMS_FS_4G = 2'b01,
    ACMS_FS_8G = 2'b10
  } acms_range_t;

  // ==========================================================================
  // Sensitivities, counts per g
  localparam int ACMS_SENS_2G = 1024;
  localparam int ACMS_SENS_4G = 512;
  localparam int ACMS_SENS_8G = 256;

  // ==========================================================================
  // Data layout
  localparam int ACMS_RAW_W  = 15;  // Raw input at 2g sensitivity, +-16g headroom
  localparam int ACMS_OUT_W  = 12;
  localparam int ACMS_AXES   = 3;
  localparam logic [7:0] ACMS_OUT_BASE = 8'h00;
  localparam logic [7:0] ACMS_OUT_LAST = 8'h05;
  localparam logic [7:0] ACMS_RD_IDLE  = 8'h00;

  typedef struct packed {
    logic signed [ACMS_RAW_W-1:0] z;
    logic signed [ACMS_RAW_W-1:0] y;
    logic signed [ACMS_RAW_W-1:0] x;
  } acms_raw_t;

  typedef struct packed {
    logic signed [ACMS_OUT_W-1:0] z;
    logic signed [ACMS_OUT_W-1:0] y;
    logic signed [ACMS_OUT_W-1:0] x;
  } acms_axes_t;

  typedef struct packed {
    logic digital;
    logic analog;
    logic sample_clk;
    logic bus;
  } acms_pwr_t;

  // ==========================================================================
  // Timing
  localparam int ACMS_CLK_NS     = 50;
  localparam int ACMS_GLITCH_NS  = 50;
  localparam int ACMS_GLITCH_CYC = (ACMS_GLITCH_NS + ACMS_CLK_NS - 1) / ACMS_CLK_NS;
  localparam int ACMS_STARTUP_US = 1000;
  localparam int ACMS_STARTUP_CYC = (ACMS_STARTUP_US * 1000 + ACMS_CLK_NS - 1) / ACMS_CLK_NS;
  localparam int ACMS_STARTUP_SMP = 2;
  localparam logic ACMS_LINE_IDLE = 1'b1;

endpackage

// ===== hw/acms_glitch_filt.sv
`timescale 1ns/1ns
module acms_glitch_filt #(
  parameter int GLITCH_CYC = acms_pkg::ACMS_GLITCH_CYC
) (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  // Line
  input  wire logic en_i,
  input  wire logic line_i,
  output logic      line_o
);

  // ==========================================================================
  // Spike suppression
  // A level must be seen on GLITCH_CYC+1 samples in a row, so any pulse no
  // wider than GLITCH_CYC cycles never reaches the output.
  logic [GLITCH_CYC:0] hist_q;
  logic                line_q;

  // Sample history
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist_q <= {(GLITCH_CYC+1){acms_pkg::ACMS_LINE_IDLE}};
    end else if (ce_i) begin
      hist_q <= {hist_q[GLITCH_CYC-1:0], line_i};
    end
  end

  // Filtered level, idle while bus disabled
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_q <= acms_pkg::ACMS_LINE_IDLE;
    end else if (ce_i) begin
      if (!en_i) begin
        line_q <= acms_pkg::ACMS_LINE_IDLE;
      end else if (&hist_q) begin
        line_q <= 1'b1;
      end else if (~|hist_q) begin
        line_q <= 1'b0;
      end
    end
  end

  assign line_o = line_q;

endmodule

// ===== hw/acms_mode_ctrl.sv
`timescale 1ns/1ns
module acms_mode_ctrl #(
  parameter int STARTUP_CYC = acms_pkg::ACMS_STARTUP_CYC,
  parameter int STARTUP_SMP = acms_pkg::ACMS_STARTUP_SMP,
  parameter int GLITCH_CYC  = acms_pkg::ACMS_GLITCH_CYC
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  // Power and mode control
  input  wire logic                 supply_ok_i,
  input  wire logic                 active_bit_i,
  input  wire logic                 sleep_req_i,
  input  wire logic                 wake_req_i,
  // Sample path
  input  wire logic                 sample_tick_i,
  input  wire acms_pkg::acms_raw_t  accel_i,
  input  wire logic                 self_test_i,
  input  wire acms_pkg::acms_raw_t  stim_i,
  input  wire logic [1:0]           range_i,
  // Bus pins
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      scl_filt_o,
  output logic                      sda_filt_o,
  // Output register readout
  input  wire logic [7:0]           rd_addr_i,
  output logic [7:0]                rd_data_o,
  // Status
  output acms_pkg::acms_mode_t      mode_o,
  output acms_pkg::acms_pwr_t       pwr_o,
  output logic                      reg_reset_o,
  output logic                      data_valid_o,
  output acms_pkg::acms_axes_t      axes_o
);

  localparam int RW = acms_pkg::ACMS_RAW_W;
  localparam int OW = acms_pkg::ACMS_OUT_W;
  localparam int CW = $clog2(STARTUP_CYC + 1);
  localparam int SW = $clog2(STARTUP_SMP + 1);

  // ==========================================================================
  // Helpers
  // Divide raw 2g-scaled counts down to the selected range and saturate.
  function automatic logic signed [OW-1:0] scale_axis(
    input logic signed [RW:0] val,
    input logic        [1:0]  rng
  );
    logic signed [RW:0] shifted;
    logic signed [RW:0] maxv;
    logic signed [RW:0] minv;
    maxv = (RW+1)'(2 ** (OW-1) - 1);
    minv = -(RW+1)'(2 ** (OW-1));
    case (rng)
      acms_pkg::ACMS_FS_4G: shifted = val >>> $clog2(acms_pkg::ACMS_SENS_2G / acms_pkg::ACMS_SENS_4G);
      acms_pkg::ACMS_FS_8G: shifted = val >>> $clog2(acms_pkg::ACMS_SENS_2G / acms_pkg::ACMS_SENS_8G);
      default:              shifted = val;
    endcase
    if (shifted > maxv) begin
      scale_axis = maxv[OW-1:0];
    end else if (shifted < minv) begin
      scale_axis = minv[OW-1:0];
    end else begin
      scale_axis = shifted[OW-1:0];
    end
  endfunction

  // Pick one output byte: MSB holds bits 11..4, LSB holds 3..0 left-justified
  function automatic logic [7:0] axis_byte(
    input logic [OW-1:0] v,
    input logic          lsb
  );
    axis_byte = lsb ? {v[3:0], 4'h0} : v[OW-1:4];
  endfunction

  // ==========================================================================
  // Mode state machine
  acms_pkg::acms_mode_t mode_q;
  acms_pkg::acms_mode_t mode_d;
  logic                 is_active;
  logic                 enter_active;

  // Sleep and wake requests act only within the active pair
  always_comb begin
    mode_d = mode_q;
    if (!supply_ok_i) begin
      mode_d = acms_pkg::ACMS_OFF;
    end else begin
      case (mode_q)
        acms_pkg::ACMS_OFF: begin
          mode_d = acms_pkg::ACMS_STBY;
        end
        acms_pkg::ACMS_STBY: begin
          if (active_bit_i) begin
            mode_d = acms_pkg::ACMS_WAKE;
          end
        end
        acms_pkg::ACMS_WAKE: begin
          if (!active_bit_i) begin
            mode_d = acms_pkg::ACMS_STBY;
          end else if (sleep_req_i) begin
            mode_d = acms_pkg::ACMS_SLEEP;
          end
        end
        acms_pkg::ACMS_SLEEP: begin
          if (!active_bit_i) begin
            mode_d = acms_pkg::ACMS_STBY;
          end else if (wake_req_i) begin
            mode_d = acms_pkg::ACMS_WAKE;
          end
        end
        default: begin
          mode_d = acms_pkg::ACMS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= acms_pkg::ACMS_OFF;
    end else if (ce_i) begin
      mode_q <= mode_d;
    end
  end

  assign is_active    = (mode_q == acms_pkg::ACMS_WAKE) || (mode_q == acms_pkg::ACMS_SLEEP);
  assign enter_active = (mode_q == acms_pkg::ACMS_STBY) && (mode_d == acms_pkg::ACMS_WAKE);

  // ==========================================================================
  // Block enables
  acms_pkg::acms_pwr_t pwr_q;

  // Registered so downstream gating sees clean levels
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q <= '0;
    end else if (ce_i) begin
      pwr_q.digital    <= (mode_d != acms_pkg::ACMS_OFF);
      pwr_q.bus        <= (mode_d != acms_pkg::ACMS_OFF);
      pwr_q.analog     <= mode_d[1];
      pwr_q.sample_clk <= mode_d[1];
    end
  end

  // Pulse that clears the designated subset on entry to active
  logic reg_reset_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_reset_q <= 1'b0;
    end else if (ce_i) begin
      reg_reset_q <= enter_active;
    end
  end

  // ==========================================================================
  // Start-up delay: the time leg first, then the sample leg
  logic [CW-1:0] wait_cnt_q;
  logic [SW-1:0] smp_cnt_q;
  logic          valid_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt_q <= '0;
      smp_cnt_q  <= '0;
      valid_q    <= 1'b0;
    end else if (ce_i) begin
      if (!is_active || enter_active) begin
        wait_cnt_q <= '0;
        smp_cnt_q  <= '0;
        valid_q    <= 1'b0;
      end else if (!valid_q) begin
        if (wait_cnt_q != CW'(STARTUP_CYC)) begin
          wait_cnt_q <= wait_cnt_q + 1'b1;
        end else if (sample_tick_i) begin
          if (smp_cnt_q == SW'(STARTUP_SMP - 1)) begin
            valid_q <= 1'b1;
          end
          smp_cnt_q <= smp_cnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Output data: scaled per axis, captured only while sampling is live
  acms_pkg::acms_axes_t axes_q;
  localparam int ACMS_N = acms_pkg::ACMS_AXES;
  acms_pkg::acms_axes_t axes_d;

  genvar gi;
  generate
    for (gi = 0; gi < ACMS_N; gi++) begin : g_axis
      logic signed [RW:0] sum;
      logic signed [RW-1:0] a;
      logic signed [RW-1:0] s;
      assign a   = accel_i[gi*RW +: RW];
      assign s   = self_test_i ? stim_i[gi*RW +: RW] : '0;
      assign sum = (RW+1)'(a) + (RW+1)'(s);
      assign axes_d[gi*OW +: OW] = scale_axis(sum, range_i);
    end
  endgenerate

  // Standby freezes the last sample; off and active entry clear it
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      axes_q <= '0;
    end else if (ce_i) begin
      if (mode_q == acms_pkg::ACMS_OFF || enter_active) begin
        axes_q <= '0;
      end else if (is_active && valid_q && sample_tick_i) begin
        axes_q <= axes_d;
      end
    end
  end

  // ==========================================================================
  // Byte readout, X MSB at the base address
  logic [7:0] rd_q;
  logic [7:0] rd_off;

  assign rd_off = rd_addr_i - acms_pkg::ACMS_OUT_BASE;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_q <= acms_pkg::ACMS_RD_IDLE;
    end else if (ce_i) begin
      if (mode_q == acms_pkg::ACMS_OFF) begin
        rd_q <= acms_pkg::ACMS_RD_IDLE;
      end else begin
        case (rd_off)
          8'h00:   rd_q <= axis_byte(axes_q.x, 1'b0);
          8'h01:   rd_q <= axis_byte(axes_q.x, 1'b1);
          8'h02:   rd_q <= axis_byte(axes_q.y, 1'b0);
          8'h03:   rd_q <= axis_byte(axes_q.y, 1'b1);
          8'h04:   rd_q <= axis_byte(axes_q.z, 1'b0);
          8'h05:   rd_q <= axis_byte(axes_q.z, 1'b1);
          default: rd_q <= acms_pkg::ACMS_RD_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Bus line filters; a dead bus reads idle so no transaction can start
  logic [1:0] line_in;
  logic [1:0] line_out;

  assign line_in = {sda_i, scl_i};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      acms_glitch_filt #(
        .GLITCH_CYC (GLITCH_CYC)
      ) u_filt (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .ce_i     (ce_i),
        .en_i     (pwr_q.bus),
        .line_i   (line_in[gi]),
        .line_o   (line_out[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Outputs
  assign scl_filt_o   = line_out[0];
  assign sda_filt_o   = line_out[1];
  assign rd_data_o    = rd_q;
  assign mode_o       = mode_q;
  assign pwr_o        = pwr_q;
  assign reg_reset_o  = reg_reset_q;
  assign data_valid_o = valid_q;
  assign axes_o       = axes_q;

endmodule

// ===== dv/acms_mode_checker.sv
`timescale 1ns/1ns
// ==========
// Port checker for the mode controller
module acms_mode_chk #(
  parameter int STARTUP_CYC = 20
) (
  // Clock and reset
  input wire logic                 mclk_i,
  input wire logic                 arst_n_i,
  input wire logic                 ce_i,
  // Inputs watched
  input wire logic                 scl_i,
  input wire logic [7:0]           rd_addr_i,
  // Outputs watched
  input wire logic [7:0]           rd_data_o,
  input wire logic                 scl_filt_o,
  input wire acms_pkg::acms_mode_t mode_o,
  input wire acms_pkg::acms_pwr_t  pwr_o,
  input wire logic                 reg_reset_o,
  input wire logic                 data_valid_o,
  input wire acms_pkg::acms_axes_t axes_o
);
  logic [15:0] act_cnt_q;
  logic [7:0]  x_hi;
  logic        act;
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Helpers
  assign x_hi = axes_o.x[11:4];
  assign act  = mode_o == acms_pkg::ACMS_WAKE || mode_o == acms_pkg::ACMS_SLEEP;
  // Cycles active, saturating so a long run cannot wrap
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      act_cnt_q <= 16'h0000;
    else if (!act)
      act_cnt_q <= 16'h0000;
    else if (act_cnt_q != 16'hFFFF)
      act_cnt_q <= act_cnt_q + 16'h0001;
  end
  property p_off_pwr;
    mode_o == acms_pkg::ACMS_OFF |-> pwr_o == 4'h0;
  endproperty
  a_off_pwr: assert property (p_off_pwr) else $error("power on in off");
  property p_stby_pwr;
    mode_o == acms_pkg::ACMS_STBY |-> pwr_o == 4'h9;
  endproperty
  a_stby_pwr: assert property (p_stby_pwr) else $error("standby power");
  property p_act_pwr;
    act |-> pwr_o == 4'hF;
  endproperty
  a_act_pwr: assert property (p_act_pwr) else $error("active power");
  property p_stby_hold;
    mode_o == acms_pkg::ACMS_STBY && $past(mode_o) == acms_pkg::ACMS_STBY
      |-> $stable(axes_o) && !data_valid_o;
  endproperty
  a_stby_hold: assert property (p_stby_hold) else $error("data moved in standby");
  property p_reg_reset;
    ce_i && mode_o == acms_pkg::ACMS_WAKE && $past(mode_o) == acms_pkg::ACMS_STBY
      |-> reg_reset_o;
  endproperty
  a_reg_reset: assert property (p_reg_reset) else $error("no reset pulse");
  property p_sleep_src;
    mode_o == acms_pkg::ACMS_SLEEP |-> $past(act);
  endproperty
  a_sleep_src: assert property (p_sleep_src) else $error("sleep outside active");
  property p_valid_late;
    $rose(data_valid_o) |-> act_cnt_q >= 16'(STARTUP_CYC);
  endproperty
  a_valid_late: assert property (p_valid_late) else $error("valid too early");
  property p_rd_x;
    ce_i && rd_addr_i == 8'h00 && mode_o != acms_pkg::ACMS_OFF |=> rd_data_o == $past(x_hi);
  endproperty
  a_rd_x: assert property (p_rd_x) else $error("x high byte");
  property p_glitch;
    $fell(scl_filt_o) |-> !$past(scl_i, 2) && !$past(scl_i, 3);
  endproperty
  a_glitch: assert property (p_glitch) else $error("spike passed");
endmodule

bind acms_mode_ctrl acms_mode_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .scl_i(scl_i),
  .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .scl_filt_o(scl_filt_o),
  .mode_o(mode_o), .pwr_o(pwr_o), .reg_reset_o(reg_reset_o),
  .data_valid_o(data_valid_o), .axes_o(axes_o)
);

// ===== dv/acms_host_model.sv
`timescale 1ns/1ns
// ==========
// Host side: mode bit and bus lines
module acms_host_model (
  // Clock
  input  wire logic mclk_i,
  // Requests from the bench
  input  wire logic act_req_i,
  input  wire logic spike_i,
  input  wire logic hold_i,
  // Toward the device
  output logic      active_bit_o,
  output logic      scl_o,
  output logic      sda_o
);
  // Lines idle at the pull-up level; a spike lasts one cycle
  initial begin
    active_bit_o = 1'b0;
    scl_o = 1'b1;
    sda_o = 1'b1;
    forever begin
      @(posedge mclk_i);
      active_bit_o <= act_req_i;
      scl_o <= !(hold_i || spike_i);
      sda_o <= !hold_i;
    end
  end
endmodule

// ===== dv/acms_mode_ctrl_bench.sv
`timescale 1ns/1ns
// ==========
// Bench for the mode controller
module acms_mode_ctrl_bench;
  localparam int STUP = 20;
  logic                 mclk_i;
  logic                 arst_n_i = 1'b0;
  logic                 ce_i = 1'b1;
  logic                 supply_ok_i = 1'b1;
  logic                 act_req = 1'b0;
  logic                 spike = 1'b0;
  logic                 hold = 1'b0;
  logic                 sleep_req_i = 1'b0;
  logic                 wake_req_i = 1'b0;
  logic                 sample_tick_i = 1'b0;
  logic                 self_test_i = 1'b0;
  logic [1:0]           range_i = 2'h0;
  logic [7:0]           rd_addr_i = 8'h00;
  logic                 rv = 1'b0;
  logic                 rv_d = 1'b0;
  acms_pkg::acms_raw_t  accel_i = '0;
  acms_pkg::acms_raw_t  stim_i = '0;
  logic                 active_bit, scl, sda, scl_filt_o, sda_filt_o, data_valid_o;
  logic [7:0]           rd_data_o;
  acms_pkg::acms_mode_t mode_o;
  acms_pkg::acms_pwr_t  pwr_o;
  logic [7:0]           exp_q[$];
  logic [11:0]          e;
  int                   bad_count = 0;
  int                   n_compared = 0;
  int                   tk = 0;
  int                   ax[3];
  int                   st[3];

  // Clock, 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  acms_host_model u_host (.mclk_i(mclk_i), .act_req_i(act_req), .spike_i(spike),
    .hold_i(hold), .active_bit_o(active_bit), .scl_o(scl), .sda_o(sda));
  acms_mode_ctrl #(.STARTUP_CYC(STUP)) u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .ce_i(ce_i), .supply_ok_i(supply_ok_i), .active_bit_i(active_bit),
    .sleep_req_i(sleep_req_i), .wake_req_i(wake_req_i), .sample_tick_i(sample_tick_i),
    .accel_i(accel_i), .self_test_i(self_test_i), .stim_i(stim_i), .range_i(range_i),
    .scl_i(scl), .sda_i(sda), .scl_filt_o(scl_filt_o), .sda_filt_o(sda_filt_o),
    .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .mode_o(mode_o), .pwr_o(pwr_o),
    .reg_reset_o(), .data_valid_o(data_valid_o), .axes_o());

  // ==========
  // Compare and report
  task automatic chk_s(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t state %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========
  // Stimulus helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Scale then clip to 12 bits; code 11 scales like 2g
  function automatic logic [11:0] ex(input int v, input logic [1:0] r);
    int s;
    s = v >>> ((r == 2'h1) ? 1 : (r == 2'h2) ? 2 : 0);
    s = (s > 2047) ? 2047 : (s < -2048) ? -2048 : s;
    return 12'(s);
  endfunction
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rd_addr_i <= a;
    rv <= 1'b1;
    exp_q.push_back(x);
    @(posedge mclk_i);
  endtask
  task automatic rd_all(input logic z);
    for (int i = 0; i < 3; i++) begin
      e = z ? 12'h000 : ex(ax[i] + (self_test_i ? st[i] : 0), range_i);
      rd(8'(2 * i), e[11:4]);
      rd(8'(2 * i + 1), {e[3:0], 4'h0});
    end
    rd(8'h06, 8'h00);
    rv <= 1'b0;
    cyc(3);
  endtask

  // Sample ticks every 8 cycles; read results compared two edges after the address
  always @(posedge mclk_i) begin
    tk <= tk + 1;
    sample_tick_i <= (tk % 8 == 0);
    rv_d <= rv;
    if (rv_d)
      chk_b(rd_data_o, exp_q.pop_front());
  end

  // ==========
  // Main sequence
  initial begin
    void'($urandom(35));
    begin : scen
    cyc(6);
    arst_n_i <= 1'b1;
    sleep_req_i <= 1'b1;
    cyc(3);
    sleep_req_i <= 1'b0;
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_STBY));
    chk_s(pwr_o, 4'h9);
    for (int i = 0; i < 3; i++) begin
      ax[i] = int'($urandom_range(8191)) - 4096;
      st[i] = int'($urandom_range(511)) - 256;
    end
    accel_i <= {15'(ax[2]), 15'(ax[1]), 15'(ax[0])};
    stim_i <= {15'(st[2]), 15'(st[1]), 15'(st[0])};
    act_req <= 1'b1;
    cyc(4);
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_WAKE));
    chk_s(pwr_o, 4'hF);
    for (int i = 0; i < 200 && data_valid_o !== 1'b1; i++)
      cyc(1);
    if (data_valid_o !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t valid never rose", $time);
      disable scen;
    end
    // Every range, self-test on for odd codes
    for (int r = 0; r < 4; r++) begin
      range_i <= 2'(r);
      self_test_i <= r[0];
      cyc(20);
      rd_all(1'b0);
    end
    // Clock enable low freezes the mode even with a sleep request pending
    ce_i <= 1'b0;
    sleep_req_i <= 1'b1;
    cyc(3);
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_WAKE));
    ce_i <= 1'b1;
    cyc(2);
    sleep_req_i <= 1'b0;
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_SLEEP));
    wake_req_i <= 1'b1;
    cyc(2);
    wake_req_i <= 1'b0;
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_WAKE));
    act_req <= 1'b0;
    cyc(4);
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_STBY));
    accel_i <= ~accel_i;
    cyc(20);
    rd_all(1'b0);
    act_req <= 1'b1;
    cyc(6);
    rd_all(1'b1);
    // A one-cycle spike must not pass; a held level must
    spike <= 1'b1;
    cyc(1);
    spike <= 1'b0;
    repeat (5) begin
      cyc(1);
      chk_s({2'b00, scl_filt_o, sda_filt_o}, 4'h3);
    end
    hold <= 1'b1;
    cyc(6);
    chk_s({2'b00, scl_filt_o, sda_filt_o}, 4'h0);
    supply_ok_i <= 1'b0;
    cyc(4);
    chk_s(4'(mode_o), 4'(acms_pkg::ACMS_OFF));
    chk_s(pwr_o, 4'h0);
    chk_s({2'b00, scl_filt_o, sda_filt_o}, 4'h3);
    rd_all(1'b1);
    end
    results();
  end
endmodule
